// file: verilog/orc_defines.svh
// Constants of the overlay region command controller.
// Assumes a 100 MHz clock and a 16-bit word-wide flash bus.
`ifndef ORC_DEFINES_SVH
`define ORC_DEFINES_SVH

// ======================================================================
// Timing
`define ORC_CLK_NS      10
`define ORC_T_WP_NS     35
`define ORC_T_WPH_NS    20
`define ORC_T_ACC_NS    70
`define ORC_T_POLL_US   1000
`define ORC_WP_CYC      4'((`ORC_T_WP_NS + `ORC_CLK_NS - 1) / `ORC_CLK_NS)
`define ORC_WPH_CYC     4'((`ORC_T_WPH_NS + `ORC_CLK_NS - 1) / `ORC_CLK_NS)
`define ORC_ACC_CYC     4'((`ORC_T_ACC_NS + `ORC_CLK_NS - 1) / `ORC_CLK_NS)
`define ORC_SYNC_CYC    4'h2
`define ORC_POLL_CYC    (`ORC_T_POLL_US * 1000 / `ORC_CLK_NS)

// ======================================================================
// Command cycles
`define ORC_A_UNL1      22'h000555
`define ORC_A_UNL2      22'h0002aa
`define ORC_D_RESET     16'h00f0
`define ORC_D_STATUS    16'h0070
`define ORC_D_UNL1      16'h00aa
`define ORC_D_UNL2      16'h0055
`define ORC_D_WORD      16'h00a0
`define ORC_D_BUF       16'h0025
`define ORC_D_CONFIRM   16'h0029
`define ORC_D_EXIT_ENT  16'h0090
`define ORC_D_EXIT      16'h0000
`define ORC_SR_READY    7
`define ORC_SR_LOCK     2
`define ORC_SR_ERR      16'h0030
`define ORC_PAGE_WORDS  8'h80

// ======================================================================
// Register map, word offsets (wb_adr_i[7:2])
`define ORC_REG_CTRL    6'h00
`define ORC_REG_ADDR    6'h01
`define ORC_REG_WDATA   6'h02
`define ORC_REG_COUNT   6'h03
`define ORC_REG_RDATA   6'h04
`define ORC_REG_STATE   6'h05
`define ORC_REG_ISTAT   6'h06
`define ORC_REG_IMASK   6'h07
`define ORC_REG_CFG     6'h08
`define ORC_CTRL_GO     8
`define ORC_CFG_ACTIVE  2
`define ORC_CFG_PROT    3
`define ORC_IRQ_DONE    0
`define ORC_IRQ_ERR     1
`define ORC_IRQ_DREQ    2

`endif

// file: verilog/orc_pkg.sv
// Types of the overlay region command controller.
// Needs nothing from orc_defines.svh; state codes are numbered here.
package orc_pkg;
  typedef enum logic [2:0] {
    ORC_OP_WRITE, ORC_OP_READ, ORC_OP_EXIT, ORC_OP_STATUS,
    ORC_OP_WORD, ORC_OP_BUF, ORC_OP_REXIT, ORC_OP_RECOVER
  } orc_op_t;
  typedef enum logic [2:0] {
    ORC_ST_IDLE  = 3'b000,
    ORC_ST_NEXT  = 3'b001,
    ORC_ST_CYC   = 3'b011,
    ORC_ST_WAITD = 3'b010,
    ORC_ST_FIN   = 3'b110
  } orc_state_t;
  typedef enum logic [1:0] {
    ORC_OV_QUERY, ORC_OV_IDENT, ORC_OV_SECURE
  } orc_overlay_t;
  typedef enum logic [2:0] {
    ORC_K_WR, ORC_K_RD, ORC_K_CHK, ORC_K_DATA, ORC_K_POLL, ORC_K_END
  } orc_kind_t;
  typedef enum logic [2:0] {
    ORC_E_NONE, ORC_E_MODE, ORC_E_LOCKED, ORC_E_RANGE, ORC_E_TIMEOUT,
    ORC_E_DEVICE
  } orc_err_t;
  typedef struct packed {
    orc_kind_t   kind;
    logic [21:0] addr;
    logic [15:0] data;
  } orc_step_t;
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        dq_oe_n;
    logic [21:0] addr;
    logic [15:0] dq;
  } orc_pins_t;
endpackage

// file: verilog/orc_ctrl.sv
// Host controller issuing overlay region command sequences to a flash.
// Assumes a classic Wishbone master and a flash that keeps its own rules.
`timescale 1ns/1ps
`default_nettype none
`include "orc_defines.svh"

module orc_ctrl
  import orc_pkg::*;
#(
  parameter int unsigned P_POLL_CYC = `ORC_POLL_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  output var  logic        irq_o,
  output var  orc_pins_t   pins_o,
  input  wire logic [15:0] dq_i
);

  // ====================================================================
  // Reset release
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ====================================================================
  // Command sequences
  function automatic orc_step_t mk(orc_kind_t k, logic [21:0] ad,
                                   logic [15:0] dt);
    mk = '{kind: k, addr: ad, data: dt};
  endfunction

  function automatic orc_step_t step_of(orc_op_t op, logic [4:0] i,
                                        logic [21:0] a, logic [21:0] ca,
                                        logic [15:0] d, logic [15:0] wc);
    orc_step_t s;
    s = mk(ORC_K_END, 22'h0, 16'h0);
    unique case (op)
      ORC_OP_WRITE: if (i == 5'h0) s = mk(ORC_K_WR, a, d);
      ORC_OP_READ:  if (i == 5'h0) s = mk(ORC_K_RD, a, 16'h0);
      ORC_OP_EXIT, ORC_OP_RECOVER: begin
        if (i == 5'h0) s = mk(ORC_K_WR, a, `ORC_D_RESET);
      end
      ORC_OP_STATUS: begin
        case (i)
          5'h0: s = mk(ORC_K_WR, `ORC_A_UNL1, `ORC_D_STATUS);
          5'h1: s = mk(ORC_K_RD, `ORC_A_UNL1, 16'h0);
          default: ;
        endcase
      end
      ORC_OP_REXIT: begin
        case (i)
          5'h0: s = mk(ORC_K_WR, `ORC_A_UNL1, `ORC_D_UNL1);
          5'h1: s = mk(ORC_K_WR, `ORC_A_UNL2, `ORC_D_UNL2);
          5'h2: s = mk(ORC_K_WR, `ORC_A_UNL1, `ORC_D_EXIT_ENT);
          5'h3: s = mk(ORC_K_WR, a, `ORC_D_EXIT);
          default: ;
        endcase
      end
      ORC_OP_WORD, ORC_OP_BUF: begin
        case (i)
          5'h0: s = mk(ORC_K_WR, `ORC_A_UNL1, `ORC_D_STATUS);
          5'h1: s = mk(ORC_K_RD, `ORC_A_UNL1, 16'h0);
          5'h2: s = mk(ORC_K_CHK, 22'h0, 16'h0);
          5'h3: s = mk(ORC_K_WR, `ORC_A_UNL1, `ORC_D_UNL1);
          5'h4: s = mk(ORC_K_WR, `ORC_A_UNL2, `ORC_D_UNL2);
          default: begin
            if (op == ORC_OP_WORD) begin
              case (i)
                5'h5: s = mk(ORC_K_WR, `ORC_A_UNL1, `ORC_D_WORD);
                5'h6: s = mk(ORC_K_DATA, ca, d);
                5'h7: s = mk(ORC_K_WR, `ORC_A_UNL1, `ORC_D_STATUS);
                5'h8: s = mk(ORC_K_RD, `ORC_A_UNL1, 16'h0);
                5'h9: s = mk(ORC_K_POLL, 22'h0, 16'h0);
                default: ;
              endcase
            end else begin
              case (i)
                5'h5: s = mk(ORC_K_WR, a, `ORC_D_BUF);
                5'h6: s = mk(ORC_K_WR, a, wc);
                5'h7: s = mk(ORC_K_DATA, ca, d);
                5'h8: s = mk(ORC_K_WR, a, `ORC_D_CONFIRM);
                5'h9: s = mk(ORC_K_WR, `ORC_A_UNL1, `ORC_D_STATUS);
                5'ha: s = mk(ORC_K_RD, `ORC_A_UNL1, 16'h0);
                5'hb: s = mk(ORC_K_POLL, 22'h0, 16'h0);
                default: ;
              endcase
            end
          end
        endcase
      end
    endcase
    return s;
  endfunction

  // ====================================================================
  // Register and sequencer state
  orc_state_t  state_ff;
  orc_op_t     op_ff;
  orc_op_t     run_op_ff;
  orc_err_t    err_ff;
  logic [4:0]  idx_ff;
  logic [21:0] addr_ff;
  logic [21:0] cur_addr_ff;
  logic [7:0]  count_ff;
  logic [7:0]  rem_ff;
  logic [15:0] wdata_ff;
  logic        dvalid_ff;
  logic        go_ff;
  logic        stay_ff;
  logic        recov_ff;
  logic [31:0] tmo_ff;
  logic [3:0]  cfg_ff;
  logic [2:0]  istat_ff;
  logic [2:0]  imask_ff;
  logic [15:0] rd_word_ff;
  logic [15:0] dq_s1_ff;
  logic [15:0] dq_s2_ff;
  logic [15:0] dq_s3_ff;
  logic [3:0]  ccnt_ff;
  logic        cyc_on_ff;
  logic        cyc_rd_ff;
  logic        cyc_done_ff;

  orc_step_t   st;
  logic        go_cyc;
  logic        take_data;
  logic        wr_hit;
  logic        cfg_clr;
  logic [2:0]  ev;
  logic [2:0]  nxt_istat;
  logic [31:0] rd_mux;
  logic        is_prog;
  logic        in_secure;
  logic        in_page;
  logic [8:0]  page_end;

  // ====================================================================
  // Step decode
  always_comb begin
    st = step_of(run_op_ff, idx_ff, addr_ff, cur_addr_ff, wdata_ff,
                 {8'h00, count_ff - 8'h01});
    if (recov_ff) st = mk(ORC_K_WR, addr_ff, `ORC_D_RESET);
    go_cyc = (state_ff == ORC_ST_NEXT) &&
             ((st.kind == ORC_K_WR) || (st.kind == ORC_K_RD) ||
              ((st.kind == ORC_K_DATA) && dvalid_ff));
    take_data = (state_ff == ORC_ST_NEXT) && (st.kind == ORC_K_DATA) &&
                dvalid_ff && !recov_ff;
  end

  // Start checks
  always_comb begin
    is_prog   = (op_ff == ORC_OP_WORD) || (op_ff == ORC_OP_BUF);
    in_secure = cfg_ff[`ORC_CFG_ACTIVE] &&
                (orc_overlay_t'(cfg_ff[1:0]) == ORC_OV_SECURE);
    page_end  = {2'b00, addr_ff[6:0]} + {1'b0, count_ff};
    in_page   = (count_ff != 8'h00) && (count_ff <= `ORC_PAGE_WORDS) &&
                (page_end <= {1'b0, `ORC_PAGE_WORDS});
  end

  // ====================================================================
  // Sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= ORC_ST_IDLE;
      run_op_ff   <= ORC_OP_WRITE;
      err_ff      <= ORC_E_NONE;
      idx_ff      <= 5'h0;
      cur_addr_ff <= 22'h0;
      rem_ff      <= 8'h0;
      stay_ff     <= 1'b0;
      recov_ff    <= 1'b0;
      tmo_ff      <= 32'h0;
    end else begin
      if (tmo_ff != 32'h0 && state_ff != ORC_ST_WAITD) begin
        tmo_ff <= tmo_ff - 32'h1;
      end
      unique case (state_ff)
        ORC_ST_IDLE: begin
          if (go_ff) begin
            run_op_ff   <= op_ff;
            idx_ff      <= 5'h0;
            cur_addr_ff <= addr_ff;
            rem_ff      <= (op_ff == ORC_OP_BUF) ? count_ff : 8'h01;
            recov_ff    <= 1'b0;
            tmo_ff      <= P_POLL_CYC;
            err_ff      <= ORC_E_NONE;
            state_ff    <= ORC_ST_NEXT;
            if (is_prog && (!in_secure || cfg_ff[`ORC_CFG_PROT])) begin
              err_ff   <= ORC_E_MODE;
              state_ff <= ORC_ST_FIN;
            end else if (!in_secure && (op_ff == ORC_OP_STATUS ||
                                        op_ff == ORC_OP_REXIT)) begin
              err_ff   <= ORC_E_MODE;
              state_ff <= ORC_ST_FIN;
            end else if (op_ff == ORC_OP_BUF && !in_page) begin
              err_ff   <= ORC_E_RANGE;
              state_ff <= ORC_ST_FIN;
            end
          end
        end
        ORC_ST_NEXT: begin
          stay_ff <= 1'b0;
          unique case (st.kind)
            ORC_K_WR, ORC_K_RD: state_ff <= ORC_ST_CYC;
            ORC_K_DATA: begin
              if (dvalid_ff) begin
                rem_ff      <= rem_ff - 8'h01;
                cur_addr_ff <= cur_addr_ff + 22'h1;
                stay_ff     <= (rem_ff != 8'h01);
                state_ff    <= ORC_ST_CYC;
              end else begin
                state_ff <= ORC_ST_WAITD;
              end
            end
            ORC_K_CHK: begin
              if (rd_word_ff[`ORC_SR_LOCK]) begin
                err_ff   <= ORC_E_LOCKED;
                state_ff <= ORC_ST_FIN;
              end else begin
                idx_ff <= idx_ff + 5'h1;
              end
            end
            ORC_K_POLL: begin
              if (rd_word_ff[`ORC_SR_READY]) begin
                if ((rd_word_ff & `ORC_SR_ERR) != 16'h0) begin
                  err_ff   <= ORC_E_DEVICE;
                  recov_ff <= 1'b1;
                end else begin
                  idx_ff <= idx_ff + 5'h1;
                end
              end else if (tmo_ff == 32'h0) begin
                err_ff   <= ORC_E_TIMEOUT;
                state_ff <= ORC_ST_FIN;
              end else begin
                idx_ff <= idx_ff - 5'h2;
              end
            end
            ORC_K_END: state_ff <= ORC_ST_FIN;
            default: state_ff <= ORC_ST_FIN;
          endcase
        end
        ORC_ST_WAITD: begin
          if (dvalid_ff) state_ff <= ORC_ST_NEXT;
        end
        ORC_ST_CYC: begin
          if (cyc_done_ff) begin
            if (recov_ff) begin
              state_ff <= ORC_ST_FIN;
            end else begin
              state_ff <= ORC_ST_NEXT;
              if (!stay_ff) idx_ff <= idx_ff + 5'h1;
            end
          end
        end
        ORC_ST_FIN: state_ff <= ORC_ST_IDLE;
        default: state_ff <= ORC_ST_IDLE;
      endcase
    end
  end

  // ====================================================================
  // Flash bus cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1_ff <= 16'h0;
      dq_s2_ff <= 16'h0;
      dq_s3_ff <= 16'h0;
    end else begin
      dq_s1_ff <= dq_i;
      dq_s2_ff <= dq_s1_ff;
      dq_s3_ff <= dq_s2_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_o      <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe_n: 1'b1,
                       addr: 22'h0, dq: 16'h0};
      ccnt_ff     <= 4'h0;
      cyc_on_ff   <= 1'b0;
      cyc_rd_ff   <= 1'b0;
      cyc_done_ff <= 1'b0;
      rd_word_ff  <= 16'h0;
    end else begin
      cyc_done_ff <= 1'b0;
      if (go_cyc && !cyc_on_ff) begin
        pins_o.addr    <= st.addr;
        pins_o.dq      <= st.data;
        pins_o.ce_n    <= 1'b0;
        pins_o.oe_n    <= (st.kind != ORC_K_RD);
        pins_o.dq_oe_n <= (st.kind == ORC_K_RD);
        cyc_rd_ff      <= (st.kind == ORC_K_RD);
        ccnt_ff        <= 4'h0;
        cyc_on_ff      <= 1'b1;
      end else if (cyc_on_ff) begin
        ccnt_ff <= ccnt_ff + 4'h1;
        if (cyc_rd_ff) begin
          if (ccnt_ff >= `ORC_ACC_CYC + `ORC_SYNC_CYC &&
              dq_s2_ff == dq_s3_ff) begin
            rd_word_ff  <= dq_s3_ff;
            pins_o.ce_n <= 1'b1;
            pins_o.oe_n <= 1'b1;
            cyc_on_ff   <= 1'b0;
            cyc_done_ff <= 1'b1;
          end
        end else begin
          if (ccnt_ff == 4'h0) pins_o.we_n <= 1'b0;
          if (ccnt_ff == `ORC_WP_CYC) pins_o.we_n <= 1'b1;
          if (ccnt_ff == `ORC_WP_CYC + `ORC_WPH_CYC) begin
            pins_o.ce_n    <= 1'b1;
            pins_o.dq_oe_n <= 1'b1;
            cyc_on_ff      <= 1'b0;
            cyc_done_ff    <= 1'b1;
          end
        end
      end
    end
  end

  // ====================================================================
  // Wishbone slave
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                        logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (o & ~m) | (n & m);
  endfunction

  logic [31:0] wv;
  logic [31:0] adr_mrg;
  logic [31:0] dat_mrg;

  always_comb begin
    wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    wv     = merge(32'h0, wb_dat_i, wb_sel_i);
    adr_mrg = merge({10'h0, addr_ff}, wb_dat_i, wb_sel_i);
    dat_mrg = merge({16'h0, wdata_ff}, wb_dat_i, wb_sel_i);
    unique case (wb_adr_i[7:2])
      `ORC_REG_CTRL:  rd_mux = {22'h0, (state_ff != ORC_ST_IDLE), 6'h0, op_ff};
      `ORC_REG_ADDR:  rd_mux = {10'h0, addr_ff};
      `ORC_REG_WDATA: rd_mux = {15'h0, dvalid_ff, wdata_ff};
      `ORC_REG_COUNT: rd_mux = {24'h0, count_ff};
      `ORC_REG_RDATA: rd_mux = {16'h0, rd_word_ff};
      `ORC_REG_STATE: rd_mux = {21'h0, idx_ff, (state_ff == ORC_ST_WAITD),
                                (state_ff != ORC_ST_IDLE), 1'b0, err_ff};
      `ORC_REG_ISTAT: rd_mux = {29'h0, istat_ff};
      `ORC_REG_IMASK: rd_mux = {29'h0, imask_ff};
      `ORC_REG_CFG:   rd_mux = {28'h0, cfg_ff};
      default:        rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h0;
      op_ff     <= ORC_OP_WRITE;
      addr_ff   <= 22'h0;
      count_ff  <= 8'h01;
      wdata_ff  <= 16'h0;
      dvalid_ff <= 1'b0;
      go_ff     <= 1'b0;
      imask_ff  <= 3'h0;
      cfg_ff    <= 4'h0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= rd_mux;
      go_ff    <= 1'b0;
      if (take_data) dvalid_ff <= 1'b0;
      if (cfg_clr) cfg_ff[`ORC_CFG_ACTIVE] <= 1'b0;
      if (wr_hit) begin
        unique case (wb_adr_i[7:2])
          `ORC_REG_CTRL: begin
            if (wb_sel_i[0]) op_ff <= orc_op_t'(wv[2:0]);
            go_ff <= wv[`ORC_CTRL_GO] && (state_ff == ORC_ST_IDLE);
          end
          `ORC_REG_ADDR:  addr_ff <= adr_mrg[21:0];
          `ORC_REG_WDATA: begin
            wdata_ff  <= dat_mrg[15:0];
            dvalid_ff <= 1'b1;
          end
          `ORC_REG_COUNT: if (wb_sel_i[0]) count_ff <= wv[7:0];
          `ORC_REG_IMASK: if (wb_sel_i[0]) imask_ff <= wv[2:0];
          `ORC_REG_CFG:   if (wb_sel_i[0]) cfg_ff <= wv[3:0];
          default: ;
        endcase
      end
    end
  end

  // ====================================================================
  // Interrupts
  always_comb begin
    ev = '0;
    ev[`ORC_IRQ_DONE] = (state_ff == ORC_ST_FIN);
    ev[`ORC_IRQ_ERR]  = (state_ff == ORC_ST_FIN) && (err_ff != ORC_E_NONE);
    ev[`ORC_IRQ_DREQ] = (state_ff == ORC_ST_NEXT) &&
                        (st.kind == ORC_K_DATA) && !dvalid_ff && !recov_ff;
    cfg_clr = (state_ff == ORC_ST_FIN) && (err_ff == ORC_E_NONE) &&
              ((run_op_ff == ORC_OP_EXIT) || (run_op_ff == ORC_OP_REXIT));
    nxt_istat = istat_ff;
    if (wr_hit && wb_adr_i[7:2] == `ORC_REG_ISTAT && wb_sel_i[0]) begin
      nxt_istat = istat_ff & ~wb_dat_i[2:0];
    end
    nxt_istat = nxt_istat | ev;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_ff <= 3'h0;
      irq_o    <= 1'b0;
    end else begin
      istat_ff <= nxt_istat;
      irq_o    <= |(nxt_istat & imask_ff);
    end
  end

endmodule

`default_nettype wire

// file: verif/orc_ctrl_sva.sv
// Checker of bus answer and flash pin timing.
// Assumes a bind to orc_ctrl; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module orc_ctrl_sva
  import orc_pkg::*;
(
  input wire logic      clk,
  input wire logic      nrst,
  input wire logic      wb_cyc_i,
  input wire logic      wb_stb_i,
  input wire logic      wb_ack_o,
  input wire orc_pins_t pins_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========
  // Properties
  ack_once_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_time_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
  we_width_a:
    assert property ($fell(pins_o.we_n) |->
      (!pins_o.we_n) [*4] ##1 pins_o.we_n) else $error("we width");
  we_drive_a:
    assert property (!pins_o.we_n |->
      !pins_o.ce_n && !pins_o.dq_oe_n && pins_o.oe_n)
      else $error("write strobe without drive");
  rd_free_a:
    assert property (!pins_o.oe_n |-> pins_o.dq_oe_n && !pins_o.ce_n)
      else $error("read while driving");
  wr_hold_a:
    assert property (!pins_o.we_n |->
      $stable(pins_o.addr) && $stable(pins_o.dq)) else $error("hold");
  we_setup_a:
    assert property ($fell(pins_o.we_n) |-> $past(!pins_o.ce_n))
      else $error("setup");
  we_tail_a:
    assert property ($rose(pins_o.we_n) |->
      (!pins_o.ce_n && !pins_o.dq_oe_n) [*2]) else $error("tail");
  ce_gap_a:
    assert property ($rose(pins_o.ce_n) |=> pins_o.ce_n)
      else $error("no idle gap");
  cover property ($fell(pins_o.we_n));
  cover property ($fell(pins_o.oe_n));
  cover property ($rose(wb_ack_o));
endmodule
`default_nettype wire

// file: verif/orc_flash_model.sv
// Behavioural flash, secure region command states only.
// Assumes write cycles latched as the write strobe rises.
`timescale 1ns/1ps
`default_nettype none
module orc_flash_model
  import orc_pkg::*;
#(
  parameter int BUSY_CYC = 20
) (
  input  wire logic        clk,
  input  wire orc_pins_t   pins,
  input  wire logic        lock_i,
  input  wire logic        hang_i,
  output var  logic [15:0] dq_o,
  output var  logic [3:0]  st_o,
  output var  logic [7:0]  n_prog,
  output var  logic [7:0]  n_words,
  output var  logic [15:0] last_w,
  output var  logic        gone_o
);
  localparam logic [3:0] SEC = 4'h0, UL1 = 4'h1, UL2 = 4'h2, EXT = 4'h3,
    WB = 4'h4, WBD = 4'h5, PG1 = 4'h6, PG = 4'h7, PROGRAM_ERROR_ABORT_STATE = 4'h8;
  logic        we_q = 1'b1, stat = 1'b0, wr, sam;
  int          wc = 0, bsy = 0;
  logic [6:0]  entry_sector_address = 7'h0;
  logic [14:0] page = 15'h0;
  logic [15:0] d, sr, rdv, last_q = 16'h0;
  logic [10:0] a;
  initial begin
    st_o = SEC;
    n_prog = 8'h0;
    n_words = 8'h0;
    last_w = 16'h0;
    gone_o = 1'b0;
  end
  assign d = pins.dq;
  assign a = pins.addr[10:0];
  assign wr = pins.we_n && !we_q && !pins.ce_n;
  // sector of each cycle against entry
  assign sam = pins.addr[21:15] == entry_sector_address;
  assign sr = {8'h0, bsy == 0, 2'b0, hang_i && st_o == PG, 1'b0, lock_i,
               2'b0};
  assign rdv = (stat || st_o == PG) ? sr : {5'h0, a};
  assign dq_o = (!pins.ce_n && !pins.oe_n) ? rdv : ~last_q;
  always @(posedge clk) begin
    we_q <= pins.we_n;
    if (!pins.ce_n && !pins.oe_n) last_q <= rdv;
    if (bsy > 0) bsy <= bsy - 1;
    // clean completion back to secure state
    if (st_o == PG && bsy == 1 && !hang_i) begin
      st_o <= SEC;
      n_prog <= n_prog + 8'h1;
    end
    if (wr) begin
      stat <= d == 16'h70 && a == 11'h555;
      case (st_o)
        SEC: if (d == 16'hf0) gone_o <= 1'b1;
          else if (d == 16'haa && a == 11'h555) st_o <= UL1;
        UL1: if (d == 16'h55 && a == 11'h2aa) st_o <= UL2;
        // entries, program ones gated by lock
        UL2: if (d == 16'h90 && a == 11'h555) st_o <= EXT;
          else if (!lock_i && d == 16'ha0 && a == 11'h555) st_o <= PG1;
          else if (!lock_i && d == 16'h25) begin
            st_o <= WB;
            entry_sector_address <= pins.addr[21:15];
            page <= pins.addr[21:7];
          end
        EXT: if (d == 16'h0 || d == 16'hf0) gone_o <= 1'b1;
        WB: begin
          wc <= int'(d);
          st_o <= (d <= 16'h7f && sam) ? WBD : PROGRAM_ERROR_ABORT_STATE;
        end
        // load within page, count down, confirm
        WBD: if (wc < 0) begin
            if (d == 16'h29 && sam) begin
              st_o <= PG;
              bsy <= BUSY_CYC;
            end
          end else if (pins.addr[21:7] == page) begin
            wc <= wc - 1;
            n_words <= n_words + 8'h1;
            last_w <= d;
          end
        PG1: begin
          st_o <= PG;
          bsy <= BUSY_CYC;
          last_w <= d;
        end
        PG: if (hang_i && d == 16'hf0) st_o <= SEC;
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Testbench: Wishbone sequences against the flash model.
// Assumes package, controller, model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import orc_pkg::*;
;
  logic        clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, lock = 1'b0, hang = 1'b0, ack, irq, gone;
  logic [7:0]  adr = 8'h0, np, nw;
  logic [31:0] wd = 32'h0, rd, s;
  logic [15:0] dq, lw, wq[$];
  logic [3:0]  mst;
  orc_pins_t   pins;
  int          fail_count = 0, comparisons = 0, ticks = 0;

  orc_ctrl #(.P_POLL_CYC(4000)) dut (
    .clk(clk), .nrst(nrst), .wb_adr_i(adr), .wb_dat_i(wd),
    .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(rd), .wb_ack_o(ack), .irq_o(irq), .pins_o(pins), .dq_i(dq));
  orc_flash_model #(.BUSY_CYC(60)) fm (
    .clk(clk), .pins(pins), .lock_i(lock), .hang_i(hang), .dq_o(dq),
    .st_o(mst), .n_prog(np), .n_words(nw), .last_w(lw), .gone_o(gone));

  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    ticks <= ticks + 1;
    if (ticks == 40000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ==========
  // Bus cycles
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    s = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(s & m, e);
  endtask
  task automatic run_op(input logic [2:0] op);
    wb(1'b1, 8'h00, {23'h0, 1'b1, 5'h0, op});
    s = 32'h10;
    while (s[4] === 1'b1) begin
      wb(1'b0, 8'h14, 32'h0);
      if (s[5] === 1'b1 && wq.size() > 0) begin
        wb(1'b1, 8'h08, {16'h0, wq.pop_front()});
        s = 32'h10;
      end
    end
  endtask
  // ==========
  // Sequence
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(8'h0c, 32'hff, 32'h1);
    rdc(8'h3c, 32'hffffffff, 32'h0);
    wb(1'b1, 8'h1c, 32'h7);
    wb(1'b1, 8'h20, 32'h6);
    run_op(3'd3);
    rdc(8'h10, 32'hffff, 32'h80);
    wb(1'b1, 8'h04, 32'h8100);
    wb(1'b1, 8'h0c, 32'h80);
    for (int i = 0; i < 128; i++) wq.push_back(16'h5a00 + 16'(i));
    run_op(3'd5);
    rdc(8'h14, 32'h7, 32'h0);
    chk(32'(nw), 32'h80);
    chk(32'(lw), 32'h5a7f);
    chk(32'(np), 32'h1);
    chk(32'(mst), 32'h0);
    rdc(8'h18, 32'h3, 32'h1);
    chk(32'(irq), 32'h1);
    wb(1'b1, 8'h1c, 32'h0);
    chk(32'(irq), 32'h0);
    wb(1'b1, 8'h1c, 32'h7);
    wb(1'b1, 8'h18, 32'h7);
    chk(32'(irq), 32'h0);
    wq.push_back(16'h1234);
    run_op(3'd4);
    chk(32'(lw), 32'h1234);
    chk(32'(np), 32'h2);
    lock <= 1'b1;
    run_op(3'd4);
    rdc(8'h14, 32'h7, 32'h2);
    lock <= 1'b0;
    hang <= 1'b1;
    wq.push_back(16'h4321);
    run_op(3'd4);
    rdc(8'h14, 32'h7, 32'h5);
    chk(32'(mst), 32'h0);
    hang <= 1'b0;
    wb(1'b1, 8'h20, 32'he);
    run_op(3'd4);
    rdc(8'h14, 32'h7, 32'h1);
    chk(32'(np), 32'h2);
    wb(1'b1, 8'h20, 32'h6);
    wb(1'b1, 8'h04, 32'h8101);
    run_op(3'd5);
    rdc(8'h14, 32'h7, 32'h3);
    run_op(3'd6);
    chk(32'(gone), 32'h1);
    rdc(8'h20, 32'hf, 32'h2);
    wb(1'b1, 8'h04, 32'h123);
    run_op(3'd1);
    rdc(8'h10, 32'hffff, 32'h123);
    wb(1'b1, 8'h20, 32'h5);
    run_op(3'd2);
    rdc(8'h14, 32'h7, 32'h0);
    rdc(8'h20, 32'hf, 32'h1);
    complete_run();
  end
endmodule

bind orc_ctrl orc_ctrl_sva u_sva (
  .clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .pins_o(pins_o));
`default_nettype wire
